// >>> hw/counter_clock_gate_routing.sv
// Clock and gate routing, status and interrupt logic in front of three counters
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module counter_clock_gate_routing #(
  parameter int NUM_COUNTERS = 3
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // Register port
  input  wire logic [7:0]              addr,
  input  wire logic [15:0]             wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [15:0]             rdata,
  // Connector pins
  input  wire logic [NUM_COUNTERS-1:0] ext_counter_clock_pin,
  input  wire logic [NUM_COUNTERS-1:0] ext_counter_gate_pin,
  // Counter side
  input  wire logic [NUM_COUNTERS-1:0] cnt_out,
  output logic      [NUM_COUNTERS-1:0] cnt_clk,
  output logic      [NUM_COUNTERS-1:0] cnt_tick,
  output logic      [NUM_COUNTERS-1:0] cnt_gate,
  // Interrupt
  output logic                         irq
);

  localparam int IRQ_W = 2 * NUM_COUNTERS;

  // Chaining and the register map assume exactly three counters
  if (NUM_COUNTERS != 3) begin : g_bad_count
    $error("counter_clock_gate_routing serves exactly three counters");
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Per-counter control fields
  counter_route_pkg::clk_src_t  clock_source_select  [NUM_COUNTERS];
  counter_route_pkg::gate_src_t gate_source_select   [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0]      clock_edge_sel;
  logic [NUM_COUNTERS-1:0]      soft_clock_bit;
  logic [NUM_COUNTERS-1:0]      gate_polarity_bit;
  logic [NUM_COUNTERS-1:0]      soft_gate_bit;
  logic [NUM_COUNTERS-1:0]      width_measure_reset;
  logic [NUM_COUNTERS-1:0]      meas_rearm;
  logic [NUM_COUNTERS-1:0]      meas_gate;
  logic [NUM_COUNTERS-1:0]      width_measure_busy;
  logic [NUM_COUNTERS-1:0]      busy_q;
  logic [NUM_COUNTERS-1:0]      out_q;
  logic [NUM_COUNTERS-1:0]      ctrl_hit;

  // Synchronisers
  logic [NUM_COUNTERS-1:0]      clk_pin_s1;
  logic [NUM_COUNTERS-1:0]      clk_pin_s2;
  logic [NUM_COUNTERS-1:0]      gate_pin_s1;
  logic [NUM_COUNTERS-1:0]      gate_pin_s2;

  // Internal clock divider
  counter_route_pkg::freq_sel_t internal_frequency_select;
  logic [9:0]                   div_cnt;
  logic [9:0]                   div_period;
  logic                         int_tick;

  // Routed levels
  logic [NUM_COUNTERS-1:0]      next_clk;
  logic [NUM_COUNTERS-1:0]      next_gate;

  // Interrupts
  logic [IRQ_W-1:0]             irq_status;
  logic [IRQ_W-1:0]             irq_enable;
  logic [IRQ_W-1:0]             irq_event;
  logic [IRQ_W-1:0]             irq_clear;

  // Two flip-flops on every connector input
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_s1  <= '0;
      clk_pin_s2  <= '0;
      gate_pin_s1 <= '0;
      gate_pin_s2 <= '0;
    end else begin
      clk_pin_s1  <= ext_counter_clock_pin;
      clk_pin_s2  <= clk_pin_s1;
      gate_pin_s1 <= ext_counter_gate_pin;
      gate_pin_s2 <= gate_pin_s1;
    end
  end

  // Shared frequency select
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      internal_frequency_select <= counter_route_pkg::freq_sel_t'(counter_route_pkg::FREQ_RESET);
    end else if (wr_stb && addr == counter_route_pkg::ADDR_FREQ_SEL) begin
      internal_frequency_select <= counter_route_pkg::freq_sel_t'(wdata[1:0]);
    end
  end

  always_comb begin
    unique case (internal_frequency_select)
      counter_route_pkg::FREQ_10M:  div_period = counter_route_pkg::DIV_10M;
      counter_route_pkg::FREQ_1M:   div_period = counter_route_pkg::DIV_1M;
      counter_route_pkg::FREQ_100K: div_period = counter_route_pkg::DIV_100K;
      counter_route_pkg::FREQ_10K:  div_period = counter_route_pkg::DIV_10K;
    endcase
  end

  // At 10 MHz the tick is high every cycle; >= keeps a faster select from stalling after a change
  assign int_tick = (div_cnt >= div_period - 10'h001);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else if (int_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  a_int_full_rate: assert property (
    internal_frequency_select == counter_route_pkg::FREQ_10M |-> int_tick)
    else $error("internal clock not ticking every cycle at the top rate");

  a_int_1m_spacing: assert property (
    (int_tick && internal_frequency_select == counter_route_pkg::FREQ_1M) |=> !int_tick [*8])
    else $error("internal clock ticks too soon at 1 MHz");

  // Per-counter routing
  for (genvar n = 0; n < NUM_COUNTERS; n++) begin : g_counter
    localparam int PREV = (n + NUM_COUNTERS - 1) % NUM_COUNTERS;

    assign ctrl_hit[n] = (addr == counter_route_pkg::ADDR_CTRL_BASE + 8'(n) * counter_route_pkg::ADDR_CTRL_STEP);

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        clock_source_select[n] <= counter_route_pkg::CLK_SRC_SOFT;
        gate_source_select[n]  <= counter_route_pkg::GATE_SRC_SOFT;
        clock_edge_sel[n]      <= counter_route_pkg::CTRL_RESET[counter_route_pkg::CLK_EDGE_BIT];
        soft_clock_bit[n]      <= counter_route_pkg::CTRL_RESET[counter_route_pkg::SOFT_CLK_BIT];
        gate_polarity_bit[n]   <= counter_route_pkg::CTRL_RESET[counter_route_pkg::GATE_POL_BIT];
        soft_gate_bit[n]       <= counter_route_pkg::CTRL_RESET[counter_route_pkg::SOFT_GATE_BIT];
        width_measure_reset[n] <= 1'b0;
      end else if (wr_stb && ctrl_hit[n]) begin
        clock_source_select[n] <= counter_route_pkg::clk_src_t'(wdata[counter_route_pkg::CLK_SRC_LSB +: 2]);
        gate_source_select[n]  <= counter_route_pkg::gate_src_t'(wdata[counter_route_pkg::GATE_SRC_LSB +: 2]);
        clock_edge_sel[n]      <= wdata[counter_route_pkg::CLK_EDGE_BIT];
        soft_clock_bit[n]      <= wdata[counter_route_pkg::SOFT_CLK_BIT];
        gate_polarity_bit[n]   <= wdata[counter_route_pkg::GATE_POL_BIT];
        soft_gate_bit[n]       <= wdata[counter_route_pkg::SOFT_GATE_BIT];
        width_measure_reset[n] <= wdata[counter_route_pkg::MEAS_RST_BIT];
      end
    end

    // Only a 0 to 1 change of the written rearm bit restarts the measurement
    assign meas_rearm[n] = wr_stb && ctrl_hit[n] && wdata[counter_route_pkg::MEAS_RST_BIT]
                           && !width_measure_reset[n];

    width_measure_gate u_measure (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .rearm    (meas_rearm[n]),
      .sig      (gate_pin_s2[n]),
      .gate_out (meas_gate[n]),
      .busy     (width_measure_busy[n])
    );

    always_comb begin
      unique case (clock_source_select[n])
        counter_route_pkg::CLK_SRC_SOFT:  next_clk[n] = soft_clock_bit[n];
        counter_route_pkg::CLK_SRC_INT:   next_clk[n] = int_tick;
        counter_route_pkg::CLK_SRC_EXT:   next_clk[n] = clk_pin_s2[n];
        counter_route_pkg::CLK_SRC_CHAIN: next_clk[n] = cnt_out[PREV];
      endcase
    end

    always_comb begin
      unique case (gate_source_select[n])
        counter_route_pkg::GATE_SRC_SOFT:    next_gate[n] = soft_gate_bit[n];
        counter_route_pkg::GATE_SRC_CHAIN:   next_gate[n] = cnt_out[PREV];
        counter_route_pkg::GATE_SRC_EXT:     next_gate[n] = gate_pin_s2[n];
        counter_route_pkg::GATE_SRC_MEASURE: next_gate[n] = meas_gate[n];
      endcase
    end

    // Falling edge is served by inverting, so the counter counts on a rising edge for every source but the internal tick
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        cnt_clk[n]  <= 1'b0;
        cnt_tick[n] <= 1'b0;
        cnt_gate[n] <= 1'b0;
      end else begin
        cnt_clk[n]  <= next_clk[n] ^ clock_edge_sel[n];
        // A free-running internal tick has no edge to find at the top rate
        cnt_tick[n] <= (clock_source_select[n] == counter_route_pkg::CLK_SRC_INT) ? int_tick
                       : ((next_clk[n] ^ clock_edge_sel[n]) && !cnt_clk[n]);
        cnt_gate[n] <= next_gate[n] ^ gate_polarity_bit[n];
      end
    end

    a_soft_clock_level: assert property (
      (clock_source_select[n] == counter_route_pkg::CLK_SRC_SOFT)
      |=> cnt_clk[n] == ($past(soft_clock_bit[n]) ^ $past(clock_edge_sel[n])))
      else $error("software clock level not applied");

    a_chain_clock_src: assert property (
      (clock_source_select[n] == counter_route_pkg::CLK_SRC_CHAIN && !clock_edge_sel[n])
      |=> cnt_clk[n] == $past(cnt_out[PREV]))
      else $error("chained clock not taken from previous counter");

    a_ext_clock_path: assert property (
      (clock_source_select[n] == counter_route_pkg::CLK_SRC_EXT) [*3]
      |-> cnt_clk[n] == ($past(ext_counter_clock_pin[n], 3) ^ $past(clock_edge_sel[n])))
      else $error("external clock pin not routed");

    a_rising_tick: assert property (
      ($past(clock_source_select[n]) != counter_route_pkg::CLK_SRC_INT)
      |-> (cnt_tick[n] == $rose(cnt_clk[n])))
      else $error("counting tick does not follow the rising applied clock");

    a_soft_gate_pol: assert property (
      (gate_source_select[n] == counter_route_pkg::GATE_SRC_SOFT)
      |=> cnt_gate[n] == ($past(soft_gate_bit[n]) ^ $past(gate_polarity_bit[n])))
      else $error("software gate level or polarity wrong");

    a_chain_gate_src: assert property (
      (gate_source_select[n] == counter_route_pkg::GATE_SRC_CHAIN)
      |=> cnt_gate[n] == ($past(cnt_out[PREV]) ^ $past(gate_polarity_bit[n])))
      else $error("chained gate not taken from previous counter");

    a_ext_gate_path: assert property (
      (gate_source_select[n] == counter_route_pkg::GATE_SRC_EXT) [*3]
      |-> cnt_gate[n] == ($past(ext_counter_gate_pin[n], 3) ^ $past(gate_polarity_bit[n])))
      else $error("external gate pin not routed");
  end

  // Event history for interrupts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= '0;
      out_q  <= '0;
    end else begin
      busy_q <= width_measure_busy;
      out_q  <= cnt_out;
    end
  end

  assign irq_event[counter_route_pkg::IRQ_DONE_LSB +: NUM_COUNTERS] = busy_q & ~width_measure_busy;
  assign irq_event[counter_route_pkg::IRQ_OUT_LSB +: NUM_COUNTERS]  = cnt_out & ~out_q;
  assign irq_clear = (wr_stb && addr == counter_route_pkg::ADDR_IRQ_CLEAR) ? wdata[IRQ_W-1:0] : '0;

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable <= '0;
    end else if (wr_stb && addr == counter_route_pkg::ADDR_IRQ_ENABLE) begin
      irq_enable <= wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= counter_route_pkg::READ_IDLE;
    end else if (!rd_stb) begin
      rdata <= counter_route_pkg::READ_IDLE;
    end else begin
      rdata <= counter_route_pkg::READ_IDLE;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (ctrl_hit[i]) begin
          rdata[counter_route_pkg::CLK_SRC_LSB +: 2]  <= clock_source_select[i];
          rdata[counter_route_pkg::CLK_EDGE_BIT]      <= clock_edge_sel[i];
          rdata[counter_route_pkg::SOFT_CLK_BIT]      <= soft_clock_bit[i];
          rdata[counter_route_pkg::GATE_SRC_LSB +: 2] <= gate_source_select[i];
          rdata[counter_route_pkg::GATE_POL_BIT]      <= gate_polarity_bit[i];
          rdata[counter_route_pkg::SOFT_GATE_BIT]     <= soft_gate_bit[i];
          rdata[counter_route_pkg::GATE_STAT_BIT]     <= cnt_gate[i];
          rdata[counter_route_pkg::OUT_STAT_BIT]      <= cnt_out[i];
          rdata[counter_route_pkg::CLK_STAT_BIT]      <= cnt_clk[i];
          rdata[counter_route_pkg::BUSY_STAT_BIT]     <= width_measure_busy[i];
        end
      end
      if (addr == counter_route_pkg::ADDR_IRQ_STATUS) begin
        rdata[IRQ_W-1:0] <= irq_status;
      end
      if (addr == counter_route_pkg::ADDR_IRQ_ENABLE) begin
        rdata[IRQ_W-1:0] <= irq_enable;
      end
    end
  end

  a_status_readback: assert property (
    (rd_stb && ctrl_hit[0]) |=> (rdata[counter_route_pkg::GATE_STAT_BIT] == $past(cnt_gate[0])
      && rdata[counter_route_pkg::CLK_STAT_BIT] == $past(cnt_clk[0])
      && rdata[counter_route_pkg::OUT_STAT_BIT] == $past(cnt_out[0])))
    else $error("status bits do not match applied levels");

  a_busy_readback: assert property (
    (rd_stb && ctrl_hit[0]) |=> rdata[counter_route_pkg::BUSY_STAT_BIT] == $past(width_measure_busy[0]))
    else $error("measurement busy bit misreported");

  a_irq_set_wins: assert property (
    (|(irq_event & irq_clear)) |=> ((irq_status & $past(irq_event & irq_clear)) == $past(irq_event & irq_clear)))
    else $error("interrupt event lost to a clear");

endmodule

// >>> hw/counter_route_pkg.sv
// Package with offsets, field layouts, codes and timing for the counter clock and gate routing
package counter_route_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL_BASE  = 8'h20;
  localparam logic [7:0] ADDR_CTRL_STEP  = 8'h02;
  localparam logic [7:0] ADDR_FREQ_SEL   = 8'h26;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h42;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h44;

  // Control and status field positions
  localparam int CLK_SRC_LSB   = 0;
  localparam int CLK_EDGE_BIT  = 2;
  localparam int SOFT_CLK_BIT  = 3;
  localparam int GATE_SRC_LSB  = 4;
  localparam int GATE_POL_BIT  = 6;
  localparam int SOFT_GATE_BIT = 7;
  localparam int MEAS_RST_BIT  = 8;
  localparam int GATE_STAT_BIT = 8;
  localparam int OUT_STAT_BIT  = 9;
  localparam int CLK_STAT_BIT  = 10;
  localparam int BUSY_STAT_BIT = 11;
  localparam int IRQ_DONE_LSB  = 0;
  localparam int IRQ_OUT_LSB   = 3;

  // Reset values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [1:0]  FREQ_RESET = 2'h0;
  localparam logic [15:0] READ_IDLE  = 16'h0000;

  // Internal clock periods and their cycle counts at 10 MHz
  localparam int CLK_SYS_NS   = 100;
  localparam int PERIOD_10M_NS = 100;
  localparam int PERIOD_1M_NS  = 1000;
  localparam int PERIOD_100K_NS = 10000;
  localparam int PERIOD_10K_NS = 100000;
  localparam logic [9:0] DIV_10M  = 10'((PERIOD_10M_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [9:0] DIV_1M   = 10'((PERIOD_1M_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [9:0] DIV_100K = 10'((PERIOD_100K_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [9:0] DIV_10K  = 10'((PERIOD_10K_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);

  typedef enum logic [1:0] {
    CLK_SRC_SOFT  = 2'b00,
    CLK_SRC_INT   = 2'b01,
    CLK_SRC_EXT   = 2'b10,
    CLK_SRC_CHAIN = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    GATE_SRC_SOFT    = 2'b00,
    GATE_SRC_CHAIN   = 2'b01,
    GATE_SRC_EXT     = 2'b10,
    GATE_SRC_MEASURE = 2'b11
  } gate_src_t;

  typedef enum logic [1:0] {
    FREQ_10M  = 2'b00,
    FREQ_1M   = 2'b01,
    FREQ_100K = 2'b10,
    FREQ_10K  = 2'b11
  } freq_sel_t;

  typedef enum logic [2:0] {
    MEAS_DONE      = 3'b000,
    MEAS_WAIT_LOW  = 3'b001,
    MEAS_WAIT_HIGH = 3'b010,
    MEAS_PASS      = 3'b011
  } meas_state_t;

endpackage

// >>> hw/width_measure_gate.sv
// Pulse width measurement gate: passes one positive cycle of the measured signal
`timescale 1ns/100ps
module width_measure_gate (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Control
  input  wire logic rearm,
  input  wire logic sig,
  // Results
  output logic      gate_out,
  output logic      busy
);

  counter_route_pkg::meas_state_t state;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= counter_route_pkg::MEAS_DONE;
    end else if (rearm) begin
      state <= counter_route_pkg::MEAS_WAIT_LOW;
    end else begin
      unique case (state)
        counter_route_pkg::MEAS_DONE: begin
          state <= counter_route_pkg::MEAS_DONE;
        end
        // A signal already high is skipped so only a whole positive cycle passes
        counter_route_pkg::MEAS_WAIT_LOW: begin
          if (!sig) state <= counter_route_pkg::MEAS_WAIT_HIGH;
        end
        counter_route_pkg::MEAS_WAIT_HIGH: begin
          if (sig) state <= counter_route_pkg::MEAS_PASS;
        end
        counter_route_pkg::MEAS_PASS: begin
          if (!sig) state <= counter_route_pkg::MEAS_DONE;
        end
        default: begin
          state <= counter_route_pkg::MEAS_DONE;
        end
      endcase
    end
  end

  assign gate_out = (state == counter_route_pkg::MEAS_PASS);
  assign busy     = (state != counter_route_pkg::MEAS_DONE);

  a_single_pass_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (gate_out && !sig && !rearm) |=> (!gate_out && !busy))
    else $error("measurement gate did not close after one positive cycle");

  a_no_reopen_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!busy && !rearm) |=> (!busy && !gate_out))
    else $error("finished measurement reopened without rearm");

endmodule

// >>> test/connector_model.sv
// Model of the connector pins and counter outputs facing the routing block
`timescale 1ns/100ps
module connector_model (
  // Clock
  input  wire logic       clk_sys,
  // Levels wanted by the bench
  input  wire logic [2:0] want_clk,
  input  wire logic [2:0] want_gate,
  input  wire logic [2:0] want_out,
  // Far side of the block
  output logic      [2:0] ext_counter_clock_pin,
  output logic      [2:0] ext_counter_gate_pin,
  output logic      [2:0] cnt_out
);
  // Levels move one edge late, so a level set just before a register write changes on the same edge as that write
  always @(posedge clk_sys) begin
    ext_counter_clock_pin <= want_clk;
    ext_counter_gate_pin  <= want_gate;
    cnt_out               <= want_out;
  end
endmodule

// >>> test/tb_counter_clock_gate_routing.sv
// Self-checking bench for the counter clock and gate routing block
`timescale 1ns/100ps
module tb_counter_clock_gate_routing;
  logic        clk_sys;
  logic        arst_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;
  logic [2:0]  ext_counter_clock_pin;
  logic [2:0]  ext_counter_gate_pin;
  logic [2:0]  cnt_out;
  logic [2:0]  cnt_clk;
  logic [2:0]  cnt_tick;
  logic [2:0]  cnt_gate;
  logic        irq;
  logic [2:0]  want_clk;
  logic [2:0]  want_gate;
  logic [2:0]  want_out;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  int          per[4] = '{1, 10, 100, 1000};

  counter_clock_gate_routing #(.NUM_COUNTERS(3)) counter_clock_gate_routing_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .ext_counter_clock_pin(ext_counter_clock_pin),
    .ext_counter_gate_pin(ext_counter_gate_pin), .cnt_out(cnt_out), .cnt_clk(cnt_clk),
    .cnt_tick(cnt_tick), .cnt_gate(cnt_gate), .irq(irq));

  connector_model connector_model_inst (
    .clk_sys(clk_sys), .want_clk(want_clk), .want_gate(want_gate), .want_out(want_out),
    .ext_counter_clock_pin(ext_counter_clock_pin), .ext_counter_gate_pin(ext_counter_gate_pin),
    .cnt_out(cnt_out));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Run takes about 13000 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe is taken
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk_word(what, exp, rdata);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic pins(input logic [2:0] c, input logic [2:0] g, input logic [2:0] o);
    @(posedge clk_sys);
    want_clk  <= c;
    want_gate <= g;
    want_out  <= o;
  endtask

  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    want_clk = 3'h0;
    want_gate = 3'h0;
    want_out = 3'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) rchk(8'h20 + 8'(2 * i), 16'h0000, "control reset");
    rchk(8'h26, 16'h0000, "frequency select read");
    wr(8'h30, 16'hFFFF);
    rchk(8'h30, 16'h0000, "unmapped read");
    rchk(8'h20, 16'h0000, "control after unmapped write");
    // Software clock and gate levels
    wr(8'h20, 16'h0008);
    cyc(2);
    chk_bits("soft clock", 3'b001, cnt_clk);
    rchk(8'h20, 16'h0408, "clock status");
    wr(8'h20, 16'h000C);
    cyc(2);
    chk_bits("falling edge select", 3'b000, cnt_clk);
    wr(8'h20, 16'h0080);
    cyc(2);
    chk_bits("soft gate", 3'b001, cnt_gate);
    rchk(8'h20, 16'h0180, "gate status");
    wr(8'h20, 16'h00C0);
    cyc(2);
    chk_bits("gate polarity", 3'b000, cnt_gate);
    // Round-robin chaining of clock and gate
    for (int i = 0; i < 3; i++) wr(8'h20 + 8'(2 * i), 16'h0013);
    for (int p = 0; p < 3; p++) begin
      pins(3'h0, 3'h0, 3'(1 << p));
      cyc(4);
      chk_bits("chained clock", 3'(1 << ((p + 1) % 3)), cnt_clk);
      chk_bits("chained gate", 3'(1 << ((p + 1) % 3)), cnt_gate);
      rchk(8'h20 + 8'(2 * p), 16'h0213, "output status");
    end
    // External pins pass a synchroniser first
    for (int i = 0; i < 3; i++) wr(8'h20 + 8'(2 * i), 16'h0022);
    pins(3'b101, 3'b010, 3'h0);
    cyc(2);
    chk_bits("clock before sync", 3'b000, cnt_clk);
    cyc(5);
    chk_bits("external clock", 3'b101, cnt_clk);
    chk_bits("external gate", 3'b010, cnt_gate);
    // Internal clock at every rate
    pins(3'h0, 3'h0, 3'h0);
    wr(8'h20, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(8'h26, 16'(c));
      cyc(1100);
      n = 0;
      repeat (2000) begin
        @(posedge clk_sys);
        #1;
        if (cnt_tick[0] === 1'b1) n++;
      end
      chk_word("internal ticks", 16'(2000 / per[c]), 16'(n));
    end
    // Width measurement with its completion interrupt
    wr(8'h44, 16'h0001);
    wr(8'h42, 16'h003F);
    rchk(8'h40, 16'h0000, "event status cleared");
    wr(8'h20, 16'h0030);
    wr(8'h20, 16'h0130);
    cyc(3);
    rchk(8'h20, 16'h0830, "measure busy");
    pins(3'h0, 3'b001, 3'h0);
    cyc(8);
    chk_bits("measure pass", 3'b001, cnt_gate);
    pins(3'h0, 3'b000, 3'h0);
    cyc(8);
    chk_bits("measure end", 3'b000, cnt_gate);
    rchk(8'h20, 16'h0030, "measure done");
    chk_bits("irq raised", 3'b001, {2'b00, irq});
    pins(3'h0, 3'b001, 3'h0);
    cyc(8);
    chk_bits("second pulse blocked", 3'b000, cnt_gate);
    rchk(8'h40, 16'h0001, "event status");
    wr(8'h44, 16'h0000);
    chk_bits("irq masked", 3'b000, {2'b00, irq});
    wr(8'h42, 16'h0001);
    wr(8'h44, 16'h0001);
    chk_bits("irq cleared", 3'b000, {2'b00, irq});
    // Output rise and its clear land on the same edge
    pins(3'h0, 3'h0, 3'b001);
    wr(8'h42, 16'h0008);
    rchk(8'h40, 16'h0008, "set beats clear");
    report_and_stop();
  end
endmodule
